// file: design/dtfg_defines.svh
// Register offsets, field positions, reset values and counts of the tone generator
`ifndef DTFG_DEFINES_SVH
`define DTFG_DEFINES_SVH

// Register offsets
`define DTFG_ADDR_HIGH_FREQ  8'h11
`define DTFG_ADDR_LOW_FREQ   8'h12
`define DTFG_ADDR_CTRL       8'h13

// Control register field positions
`define DTFG_CTRL_MELODY_BIT 0
`define DTFG_CTRL_DIVIDE_BIT 1
`define DTFG_CTRL_CLKOUT_BIT 2

// Reset values
`define DTFG_FREQ_RESET      8'h00
`define DTFG_CTRL_RESET      3'h0

// Synthesizer counts
`define DTFG_PHASE_LAST      5'h16
`define DTFG_MELODY_HIGH     5'h0C
`define DTFG_DIVIDE_LAST     2'h2

// Low group gain, 2 dB down, as a fraction of 256
`define DTFG_LOW_GAIN        9'sh0CB

`endif

// file: design/dtfg_pkg.sv
// Types shared by the tone generator files
package dtfg_pkg;

  // One register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Clock and melody control fields
  typedef struct packed {
    logic tone_clock_out_enable;
    logic tone_clock_div_by_three;
    logic melody_out_enable;
  } ctrl_t;

  // State shown by one sine synthesizer
  typedef struct packed {
    logic              running;
    logic [4:0]        phase;
    logic signed [7:0] sample;
  } synth_out_t;

endpackage

// file: design/tone_synth.sv
// One sine synthesizer: divide-by-(value+2) prescaler and 23-step sine table
`timescale 1ns/1ps
`default_nettype none
`include "dtfg_defines.svh"

module tone_synth (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              tone_tick,
  input  wire logic [7:0]        freq_value,
  output dtfg_pkg::synth_out_t   synth_out
);

  logic [8:0]        pre_cnt_r;
  logic [4:0]        phase_r;
  logic [7:0]        value_r;
  logic signed [7:0] sample_r;
  logic              halted;
  logic              wrap;

  // Sine table, 23 steps over one period
  function automatic logic signed [7:0] sine_of(input logic [4:0] p);
    case (p)
      5'h00: sine_of = 8'sh00;  5'h01: sine_of = 8'sh22;
      5'h02: sine_of = 8'sh42;  5'h03: sine_of = 8'sh5D;
      5'h04: sine_of = 8'sh71;  5'h05: sine_of = 8'sh7C;
      5'h06: sine_of = 8'sh7F;  5'h07: sine_of = 8'sh78;
      5'h08: sine_of = 8'sh68;  5'h09: sine_of = 8'sh50;
      5'h0A: sine_of = 8'sh33;  5'h0B: sine_of = 8'sh11;
      5'h0C: sine_of = 8'shEF;  5'h0D: sine_of = 8'shCD;
      5'h0E: sine_of = 8'shB0;  5'h0F: sine_of = 8'sh98;
      5'h10: sine_of = 8'sh88;  5'h11: sine_of = 8'sh81;
      5'h12: sine_of = 8'sh84;  5'h13: sine_of = 8'sh8F;
      5'h14: sine_of = 8'shA3;  5'h15: sine_of = 8'shBE;
      5'h16: sine_of = 8'shDE;
      default: sine_of = 8'sh00;
    endcase
  endfunction

  assign halted = (freq_value == 8'h00);
  assign wrap   = (pre_cnt_r == ({1'b0, value_r} + 9'h001));

  // Prescaler and phase; the value is taken at each prescaler wrap
  // so a new setting never cuts a step short
  always_ff @(posedge clock) begin
    if (sys_rst || halted) begin
      pre_cnt_r <= 9'h000;
      phase_r   <= 5'h00;
      value_r   <= freq_value;
    end else if (tone_tick) begin
      if (wrap) begin
        pre_cnt_r <= 9'h000;
        value_r   <= freq_value;
        phase_r   <= (phase_r == `DTFG_PHASE_LAST) ? 5'h00 : phase_r + 5'h01;
      end else begin
        pre_cnt_r <= pre_cnt_r + 9'h001;
      end
    end
  end

  // Registered sample, silent while halted
  always_ff @(posedge clock) begin
    if (sys_rst || halted) begin
      sample_r <= 8'sh00;
    end else begin
      sample_r <= sine_of(phase_r);
    end
  end

  assign synth_out.running = !halted;
  assign synth_out.phase   = phase_r;
  assign synth_out.sample  = sample_r;

endmodule // tone_synth

`default_nettype wire

// file: design/dual_tone_frequency_generator.sv
// Dual tone frequency generator core: registers, clock divider, melody and tone sum
//
// Operation
// - Melody high 12 of 23 tone steps
// - Melody frequency set only by high group
// - Melody works for high values down to 2
// - High sine keeps running during melody
// - Tone clock is crystal, or crystal/3
// - Clock pin carries tone clock when enabled
// - Each frequency register drives own synthesizer
// - Low sine scaled 2 dB below high
// - Both sines summed into one output
// - Zero value halts only its synthesizer
// - Both zero shuts generator off
// - Output frequency is clock over 23(x+2)
// - Melody enable bit 0 selects melody pin
// - Melody rests high when high value zero
// - Clock enable clear gives plain port line
// - Frequency registers write-only, control read-write
`timescale 1ns/1ps
`default_nettype none
`include "dtfg_defines.svh"

module dual_tone_frequency_generator (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire dtfg_pkg::reg_req_t bus_req,
  output logic [7:0]             rd_data,
  input  wire logic              melody_port_latch,
  input  wire logic              tone_clock_port_latch,
  output logic                   melody_pin,
  output logic                   tone_clock_out_pin,
  output logic signed [9:0]      tone_sample,
  output logic                   tone_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]            high_group_freq_reg_r;
  logic [7:0]            low_group_freq_reg_r;
  dtfg_pkg::ctrl_t       clock_melody_ctrl_reg_r;
  logic [7:0]            rd_data_r;
  logic [1:0]            div_cnt_r;
  logic [1:0]            div_cnt_nxt;
  logic                  div_phase_r;
  logic                  tone_clock_div_by_three;
  logic                  tone_clock_out_enable;
  logic                  melody_out_enable;
  logic                  gen_on;
  logic                  tone_tick;
  logic                  melody_level_nxt;
  logic                  melody_pin_r;
  logic signed [9:0]     tone_sample_r;
  logic signed [16:0]    low_prod;
  logic signed [7:0]     low_scaled;
  logic signed [9:0]     tone_sum_nxt;
  dtfg_pkg::synth_out_t  high_out;
  dtfg_pkg::synth_out_t  low_out;

  assign tone_clock_div_by_three = clock_melody_ctrl_reg_r.tone_clock_div_by_three;
  assign tone_clock_out_enable   = clock_melody_ctrl_reg_r.tone_clock_out_enable;
  assign melody_out_enable       = clock_melody_ctrl_reg_r.melody_out_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  // High group frequency, write-only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      high_group_freq_reg_r <= `DTFG_FREQ_RESET;
    end else if (bus_req.wr && bus_req.addr == `DTFG_ADDR_HIGH_FREQ) begin
      high_group_freq_reg_r <= bus_req.wdata;
    end
  end

  // Low group frequency, write-only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      low_group_freq_reg_r <= `DTFG_FREQ_RESET;
    end else if (bus_req.wr && bus_req.addr == `DTFG_ADDR_LOW_FREQ) begin
      low_group_freq_reg_r <= bus_req.wdata;
    end
  end

  // Clock and melody control; upper bits are not stored and read zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clock_melody_ctrl_reg_r <= `DTFG_CTRL_RESET;
    end else if (bus_req.wr && bus_req.addr == `DTFG_ADDR_CTRL) begin
      clock_melody_ctrl_reg_r.tone_clock_out_enable <= bus_req.wdata[`DTFG_CTRL_CLKOUT_BIT];
      clock_melody_ctrl_reg_r.tone_clock_div_by_three <= bus_req.wdata[`DTFG_CTRL_DIVIDE_BIT];
      clock_melody_ctrl_reg_r.melody_out_enable <= bus_req.wdata[`DTFG_CTRL_MELODY_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Only the control register reads back; write-only and unmapped read zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_data_r <= 8'h00;
    end else if (bus_req.rd && bus_req.addr == `DTFG_ADDR_CTRL) begin
      rd_data_r <= {5'h00, clock_melody_ctrl_reg_r};
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  assign rd_data = rd_data_r;

  ////////////////////////////////////////////////////////////////////////////
  // Tone clock divider

  // Free running modulo-3 count; it also shapes the clock output pin
  assign div_cnt_nxt = (div_cnt_r == `DTFG_DIVIDE_LAST) ? 2'h0 : div_cnt_r + 2'h1;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_cnt_r <= 2'h0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  // Registered divided clock level, high one crystal cycle in three
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_phase_r <= 1'b0;
    end else begin
      div_phase_r <= (div_cnt_nxt == 2'h0);
    end
  end

  // Generator power gate: ticks stop when both values are zero
  assign gen_on    = (high_group_freq_reg_r != 8'h00)
                  || (low_group_freq_reg_r != 8'h00);
  assign tone_tick = gen_on
                  && (!tone_clock_div_by_three || div_cnt_r == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Synthesizers

  // One synthesizer per frequency register
  tone_synth u_high_synth (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .tone_tick  (tone_tick),
    .freq_value (high_group_freq_reg_r),
    .synth_out  (high_out)
  );

  tone_synth u_low_synth (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .tone_tick  (tone_tick),
    .freq_value (low_group_freq_reg_r),
    .synth_out  (low_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Tone sum

  // Low group times 203/256, about 2 dB down; no rounding, a small bias
  // is below the filter's resolution
  assign low_prod   = low_out.sample * `DTFG_LOW_GAIN;
  assign low_scaled = low_prod[15:8];
  assign tone_sum_nxt = {{2{high_out.sample[7]}}, high_out.sample}
                      + {{2{low_scaled[7]}}, low_scaled};

  // Summed sample; it keeps running alongside the melody square wave
  always_ff @(posedge clock) begin
    if (sys_rst || !gen_on) begin
      tone_sample_r <= 10'sh000;
    end else begin
      tone_sample_r <= tone_sum_nxt;
    end
  end

  assign tone_sample = tone_sample_r;
  assign tone_active = gen_on;

  ////////////////////////////////////////////////////////////////////////////
  // Melody output

  // Square wave from the high group phase only; no filter limits its range
  always_comb begin
    if (!melody_out_enable) begin
      melody_level_nxt = melody_port_latch;
    end else if (high_group_freq_reg_r == 8'h00) begin
      melody_level_nxt = 1'b1;
    end else begin
      melody_level_nxt = (high_out.phase < `DTFG_MELODY_HIGH);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      melody_pin_r <= 1'b1;
    end else begin
      melody_pin_r <= melody_level_nxt;
    end
  end

  assign melody_pin = melody_pin_r;

  ////////////////////////////////////////////////////////////////////////////
  // Tone clock output

  // At divide-by-one the crystal itself goes out; a flop cannot toggle at
  // the full crystal rate, so the clock is muxed here on purpose
  always_comb begin
    if (!tone_clock_out_enable) begin
      tone_clock_out_pin = tone_clock_port_latch;
    end else if (tone_clock_div_by_three) begin
      tone_clock_out_pin = div_phase_r;
    end else begin
      tone_clock_out_pin = clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_div_one_tick: assert property (
    @(posedge clock) disable iff (sys_rst)
    (gen_on && !tone_clock_div_by_three) |-> tone_tick)
    else $error("tone tick missing at divide by one");

  a_div_three_gap: assert property (
    @(posedge clock) disable iff (sys_rst)
    (tone_tick && tone_clock_div_by_three)
    |=> (!tone_tick || !tone_clock_div_by_three)
        ##1 (!tone_tick || !tone_clock_div_by_three))
    else $error("tone tick too close at divide by three");

  a_shutdown_off: assert property (
    @(posedge clock) disable iff (sys_rst)
    (high_group_freq_reg_r == 8'h00 && low_group_freq_reg_r == 8'h00)
    |-> (!tone_tick && !tone_active) ##1 (tone_sample == 10'sh000))
    else $error("generator still running with both values zero");

  a_melody_rest_high: assert property (
    @(posedge clock) disable iff (sys_rst)
    (melody_out_enable && high_group_freq_reg_r == 8'h00) |=> melody_pin)
    else $error("melody pin not high with zero high value");

  a_melody_port_mode: assert property (
    @(posedge clock) disable iff (sys_rst)
    !melody_out_enable |=> (melody_pin == $past(melody_port_latch)))
    else $error("melody pin does not follow port latch");

  a_melody_duty: assert property (
    @(posedge clock) disable iff (sys_rst)
    (melody_out_enable && high_group_freq_reg_r != 8'h00)
    |=> (melody_pin == ($past(high_out.phase) < 5'h0C)))
    else $error("melody level wrong for phase step");

  a_clock_port_mode: assert property (
    @(posedge clock) disable iff (sys_rst)
    !tone_clock_out_enable |-> (tone_clock_out_pin == tone_clock_port_latch))
    else $error("clock pin does not follow port latch");

  a_clock_div_level: assert property (
    @(posedge clock) disable iff (sys_rst)
    (tone_clock_out_enable && tone_clock_div_by_three)
    |-> (tone_clock_out_pin == (div_cnt_r == 2'h0)))
    else $error("divided clock out of step");

  a_high_halt: assert property (
    @(posedge clock) disable iff (sys_rst)
    (high_group_freq_reg_r == 8'h00 && low_group_freq_reg_r != 8'h00)
    |-> low_out.running ##1 (high_out.sample == 8'sh00))
    else $error("zero high value did not halt only its synthesizer");

  a_low_halt: assert property (
    @(posedge clock) disable iff (sys_rst)
    (low_group_freq_reg_r == 8'h00 && high_group_freq_reg_r != 8'h00)
    |-> high_out.running ##1 (low_out.sample == 8'sh00))
    else $error("zero low value did not halt only its synthesizer");

  a_high_runs: assert property (
    @(posedge clock) disable iff (sys_rst)
    (melody_out_enable && high_group_freq_reg_r != 8'h00)
    |-> high_out.running && tone_active)
    else $error("high sine stopped during melody");

  a_tone_sum: assert property (
    @(posedge clock) disable iff (sys_rst)
    gen_on |=> (tone_sample == $past(tone_sum_nxt)))
    else $error("tone sum not registered");

  a_read_ctrl: assert property (
    @(posedge clock) disable iff (sys_rst)
    (bus_req.rd && bus_req.addr == 8'h13)
    |=> (rd_data == {5'h00, $past(clock_melody_ctrl_reg_r)}))
    else $error("control read data wrong");

  a_read_wo_zero: assert property (
    @(posedge clock) disable iff (sys_rst)
    (bus_req.rd && (bus_req.addr == 8'h11 || bus_req.addr == 8'h12))
    |=> (rd_data == 8'h00))
    else $error("write-only register read nonzero");

  a_high_write: assert property (
    @(posedge clock) disable iff (sys_rst)
    (bus_req.wr && bus_req.addr == 8'h11)
    |=> (high_group_freq_reg_r == $past(bus_req.wdata)))
    else $error("high group value not stored");

  a_low_write: assert property (
    @(posedge clock) disable iff (sys_rst)
    (bus_req.wr && bus_req.addr == 8'h12)
    |=> (low_group_freq_reg_r == $past(bus_req.wdata)))
    else $error("low group value not stored");

  a_ctrl_write: assert property (
    @(posedge clock) disable iff (sys_rst)
    (bus_req.wr && bus_req.addr == 8'h13)
    |=> ({tone_clock_out_enable, tone_clock_div_by_three, melody_out_enable}
         == $past(bus_req.wdata[2:0])))
    else $error("control bits not stored");

  a_phase_range: assert property (
    @(posedge clock) disable iff (sys_rst)
    (high_out.phase <= 5'h16 && low_out.phase <= 5'h16))
    else $error("phase step beyond last of 23");

  a_phase_step: assert property (
    @(posedge clock) disable iff (sys_rst)
    (high_out.phase != $past(high_out.phase))
    |-> (high_out.phase == 5'h00 || high_out.phase == $past(high_out.phase) + 5'h01))
    else $error("high phase skipped a step");

  // Scaled low sample must always sit closer to zero than the raw one
  a_low_gain: assert property (
    @(posedge clock) disable iff (sys_rst)
    (low_out.sample != 8'sh00)
    |-> ((low_out.sample > 8'sh00) ? (low_scaled < low_out.sample)
                                    : (low_scaled > low_out.sample)))
    else $error("low group sample not attenuated");

endmodule // dual_tone_frequency_generator

`default_nettype wire

// file: dv/tone_line_model.sv
// Far-side model: ringer listening on the melody pin, with the shared pin's port latch
`timescale 1ns/1ps
`default_nettype none

module tone_line_model (
  input  wire logic        clock,
  input  wire logic        melody_pin,
  output logic             melody_port_latch,
  output logic [15:0]      period_r,
  output logic [15:0]      high_r,
  output logic [7:0]       rises_r
);
  logic        prev_r = 1'b1;
  logic [15:0] cnt_r  = 16'h0000;
  logic [15:0] hcnt_r = 16'h0000;

  initial begin
    period_r = 16'h0000;
    high_r   = 16'h0000;
    rises_r  = 8'h00;
  end

  // Latch stays high so the port drive never fights the melody drive
  assign melody_port_latch = 1'b1;

  // Run lengths between rising edges; the first one after a change is partial
  always @(posedge clock) begin
    prev_r <= melody_pin;
    if (melody_pin === 1'b1 && prev_r === 1'b0) begin
      period_r <= cnt_r;
      high_r   <= hcnt_r;
      cnt_r    <= 16'h0001;
      hcnt_r   <= 16'h0001;
      rises_r  <= rises_r + 8'h01;
    end else begin
      cnt_r  <= cnt_r + 16'h0001;
      hcnt_r <= hcnt_r + {15'h0000, melody_pin === 1'b1};
    end
  end
endmodule // tone_line_model

`default_nettype wire

// file: dv/dual_tone_frequency_generator_tb_top.sv
// Testbench: register access, melody timing, clock output and tone sum checks
`timescale 1ns/1ps
`default_nettype none

module dual_tone_frequency_generator_tb_top;
  logic               clock     = 1'b0;
  logic               sys_rst   = 1'b1;
  dtfg_pkg::reg_req_t req       = '0;
  logic               clk_latch = 1'b1;
  logic [7:0]         rd_data;
  logic               melody_port_latch;
  logic               melody_pin;
  logic               tone_clock_out_pin;
  logic               tone_active;
  logic signed [9:0]  tone_sample;
  logic [15:0]        period_r;
  logic [15:0]        high_r;
  logic [7:0]         rises_r;
  logic [7:0]         rdv;
  int                 err_total = 0;
  int                 tests_run = 0;
  int                 n;
  int                 pk;

  always #5 clock = ~clock;

  dual_tone_frequency_generator u_dual_tone_frequency_generator (
    .clock(clock), .sys_rst(sys_rst), .bus_req(req), .rd_data(rd_data),
    .melody_port_latch(melody_port_latch), .tone_clock_port_latch(clk_latch),
    .melody_pin(melody_pin), .tone_clock_out_pin(tone_clock_out_pin),
    .tone_sample(tone_sample), .tone_active(tone_active));

  tone_line_model u_tone_line_model (
    .clock(clock), .melody_pin(melody_pin), .melody_port_latch(melody_port_latch),
    .period_r(period_r), .high_r(high_r), .rises_r(rises_r));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and shared tasks
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Single-cycle strobes, raised and dropped just after rising edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    #1;
    d = rd_data;
  endtask

  // Bounded wait for k more rising edges on the melody pin
  task automatic wait_rises(input logic [7:0] k);
    logic [7:0] tgt;
    int i;
    tgt = rises_r + k;
    i = 0;
    while (rises_r != tgt && i < 3000) begin
      @(posedge clock);
      i++;
    end
    if (rises_r != tgt) begin
      err_total++;
      $display("[FAIL] %0t melody edge never came", $time);
      summarize();
    end
  endtask

  // Sample changes and highest positive value of the tone sum over cyc cycles
  task automatic watch(input int cyc, output int c, output int p);
    logic signed [9:0] last;
    c = 0;
    p = 0;
    last = tone_sample;
    repeat (cyc) begin
      @(posedge clock);
      #1;
      if (tone_sample !== last) c++;
      if (tone_sample > p) p = tone_sample;
      last = tone_sample;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    chk(melody_pin, 16'h0001);
    chk(tone_active, 16'h0000);
    wr(8'h11, 8'h7F);
    wr(8'h12, 8'hDD);
    rd(8'h11, rdv);
    chk(rdv, 16'h0000);
    rd(8'h12, rdv);
    chk(rdv, 16'h0000);
    wr(8'h13, 8'hFF);
    rd(8'h13, rdv);
    chk(rdv, 16'h0007);
    rd(8'h14, rdv);
    chk(rdv, 16'h0000);
    wr(8'h13, 8'h00);
    $display("test registers done");

    // Shortest melody value, high group sine keeps running beside it
    wr(8'h12, 8'h00);
    wr(8'h11, 8'h02);
    wr(8'h13, 8'h01);
    wait_rises(8'h02);
    chk(period_r, 16'd92);
    chk(high_r, 16'd48);
    watch(100, n, pk);
    chk(16'(n > 0), 16'h0001);
    chk(16'(pk >= 120 && pk <= 127), 16'h0001);
    wr(8'h12, 8'hDD);
    wait_rises(8'h02);
    chk(period_r, 16'd92);
    watch(300, n, pk);
    chk(16'(pk > 127 && pk <= 227), 16'h0001);
    $display("test melody done");

    // Divide by three stretches every count threefold
    wr(8'h13, 8'h03);
    wait_rises(8'h02);
    chk(period_r, 16'd276);
    chk(high_r, 16'd144);
    // New value on the fly, no restart
    wr(8'h13, 8'h01);
    wr(8'h11, 8'h04);
    wait_rises(8'h02);
    chk(period_r, 16'd138);
    chk(high_r, 16'd72);
    $display("test divider done");

    // High group zero: melody rests high, low sine alone and 2 dB down
    wr(8'h11, 8'h00);
    repeat (3) @(posedge clock);
    rdv = rises_r;
    // Long enough to cover one whole low group period
    watch(5200, n, pk);
    chk(melody_pin, 16'h0001);
    chk(rises_r, rdv);
    chk(tone_active, 16'h0001);
    chk(16'(n > 0), 16'h0001);
    chk(16'(pk >= 90 && pk <= 100), 16'h0001);
    wr(8'h12, 8'h00);
    #1;
    chk(tone_active, 16'h0000);
    watch(50, n, pk);
    watch(50, n, pk);
    chk(16'(n), 16'h0000);
    $display("test halt done");

    // Clock output: crystal rate, one third rate, then plain port line
    wr(8'h11, 8'h02);
    wr(8'h13, 8'h04);
    @(posedge clock);
    #1;
    chk(tone_clock_out_pin, 16'h0001);
    @(negedge clock);
    #1;
    chk(tone_clock_out_pin, 16'h0000);
    wr(8'h13, 8'h06);
    n = 0;
    repeat (9) begin
      @(posedge clock);
      #2;
      if (tone_clock_out_pin === 1'b1) n++;
    end
    chk(16'(n), 16'd3);
    wr(8'h13, 8'h00);
    clk_latch <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(tone_clock_out_pin, 16'h0000);
    clk_latch <= 1'b1;
    $display("test clock output done");
    summarize();
  end
endmodule // dual_tone_frequency_generator_tb_top

`default_nettype wire
